// ==== inc/ctml_pkg.sv ====
// Purpose: constants and types shared by the console message link.
// Assumes: 40 MHz system clock; the console supplies the bit clock.
// Notes: the character codes and header classes are settable at the top.
//
// Function
// - Terminator character ends an inbound message; later characters are refused.
// - Inbound page message ends at first terminator, after a full page plus two characters at most.
// - Inbound bad parity aborts the transfer and requests an interrupt.
// - Bits move serially at 720,000 b/s +-15 %, on the console clock.
// - Outbound message class comes only from its first header character.
// - Outbound control message ends after sixteen characters; the terminator is not looked for.
// - After a full outbound page the second character after it ends the transfer.
// - Outbound bad parity aborts the transfer and requests an interrupt.
// - Parity-ignore toggle keeps a transfer going despite bad parity.
`default_nettype none
package ctml_pkg;
  // System clock
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_PERIOD_NS = 25;
  // Link rate and the fastest bit the synchroniser must follow
  localparam int LINK_BPS = 720_000;
  localparam int LINK_TOL_PCT = 15;
  localparam int LINK_FAST_BPS = LINK_BPS * (100 + LINK_TOL_PCT) / 100;
  localparam int BIT_MIN_CYC = CLK_HZ / LINK_FAST_BPS;
  localparam int SYNC_MIN_CYC = 4;
  // Console clear cycle, used as the ready timeout
  localparam int CLEAR_CYCLE_MS = 17;
  localparam int CLEAR_CYC = CLEAR_CYCLE_MS * (CLK_HZ / 1000);
  // Character format
  localparam int CHAR_W_DEF = 6;
  localparam logic [5:0] EOM_CODE = 6'h0f;
  localparam logic [5:0] CTRL_HDR_MASK = 6'h30;
  localparam logic [5:0] CTRL_HDR_VAL = 6'h30;
  // Page geometry and message lengths
  localparam int PAGE_LINES = 37;
  localparam int LINE_CHARS = 64;
  localparam int PAGE_CHARS = PAGE_LINES * LINE_CHARS;
  localparam int PAGE_WORDS = 296;
  localparam int PAGE_STORE = 3;
  localparam int KEY_COUNT = 34;
  localparam int CTRL_IN_CHARS = 4;
  localparam int CTRL_OUT_CHARS = 16;
  localparam int MSG_LIMIT = PAGE_CHARS + 2;
  localparam int CNT_W = 12;
  // Synchronised pins
  localparam int SYNC_PINS = 5;
  localparam int PIN_CLK = 0;
  localparam int PIN_RXD = 1;
  localparam int PIN_RXF = 2;
  localparam int PIN_RDY = 3;
  localparam int PIN_AVL = 4;
  // Buffer
  localparam int BUF_DEPTH = 2;
  typedef enum logic [1:0] {TX_IDLE, TX_LOAD, TX_SHIFT} ctml_tx_st_t;
endpackage
`default_nettype wire

// ==== sim/ctml_con_model.sv ====
// Purpose: behavioural display console at the far end of the link.
// Assumes: bit clock runs only inside frames; no pull on the data line.
// Notes: outbound bits are taken on the rising edge, one idle bit per char.
`timescale 1ns/10ps
`default_nettype none
module ctml_con_model (
  output logic con_clk,          // Bit clock
  output logic con_rx_data,      // Data towards the link
  output logic con_rx_frame,     // Inbound frame
  output logic con_ready,        // Can take output
  output logic con_msg_avail,    // Key message waiting
  input wire logic con_select,   // Scanner picked us
  input wire logic con_tx_data,  // Data from the link
  input wire logic con_tx_frame  // Outbound frame
);
  localparam realtime HALF = 694.4;
  logic rx_on;
  logic [6:0] sh;
  int k;
  logic [6:0] txq[$];
  ////////////////////////////////////////////////////////////////////////
  // Idle pins at start
  initial
  begin
    rx_on = 1'b0;
    con_clk = 1'b0;
    con_rx_data = 1'b0;
    con_rx_frame = 1'b0;
    con_msg_avail = 1'b0;
  end
  // busy while holding request; no clear cycle modelled
  assign con_ready = ~con_msg_avail;
  // request stays up until the scanner selects us
  always @(posedge con_select)
    con_msg_avail = 1'b0;
  always
  begin
    wait (rx_on || con_tx_frame === 1'b1);
    #HALF con_clk = 1'b1;
    #HALF con_clk = 1'b0;
  end
  // LSB first, parity last, no parity check here
  always @(posedge con_clk)
  begin
    if (con_tx_frame === 1'b1)
    begin
      if (k > 0 && (k - 1) % 8 < 7)
        sh[(k - 1) % 8] = con_tx_data;
      if (k > 0 && (k - 1) % 8 == 6)
        txq.push_back(sh);
      k++;
    end
  end
  // New outbound frame restarts bit count
  always @(posedge con_tx_frame)
    k = 0;
  ////////////////////////////////////////////////////////////////////////
  // message-available level
  task automatic hold(input logic v);
    con_msg_avail = v;
  endtask
  task automatic send(input logic [6:0] cs[$]);
    con_rx_data = cs[0][0];
    con_rx_frame = 1'b1;
    rx_on = 1'b1;
    for (int i = 0; i < cs.size(); i++)
      for (int b = 0; b < 7; b++)
        if (i + b > 0)
        begin
          @(negedge con_clk);
          con_rx_data = cs[i][b];
        end
    @(negedge con_clk);
    rx_on = 1'b0;
    con_rx_frame = 1'b0;
    con_rx_data = ~con_rx_data; // Released line keeps no stale bit
  endtask
endmodule
`default_nettype wire

// ==== sim/tb_ctml_link.sv ====
// Purpose: self-checking bench for the console message link.
// Assumes: console model drives the link pins; 40 MHz system clock.
// Notes: a full outbound page would run far too long, so is not sent.
`timescale 1ns/10ps
`default_nettype none
module tb_ctml_link;
  logic clk_sys, rst, con_clk, con_rx_data, con_rx_frame, con_ready;
  logic con_msg_avail, con_select, con_tx_data, con_tx_frame, scan_sel;
  logic msg_avail, parity_ignore, rx_char_valid, rx_char_ready, rx_done;
  logic tx_start, tx_char_valid, tx_char_ready, tx_busy, tx_done;
  logic xfer_abort, irq_req;
  logic [6:0] rx_char, tx_char;
  logic [6:0] rxq[$];
  logic [5:0] end_of_message_char;
  int err_count = 0;
  int check_count = 0;
  int n_d, n_i, n_a;
  ctml_link #(.CLEAR_WAIT_CYC(200)) i_ctml_link (.clk_sys(clk_sys), .rst(rst),
    .con_clk(con_clk), .con_rx_data(con_rx_data), .con_rx_frame(con_rx_frame),
    .con_ready(con_ready), .con_msg_avail(con_msg_avail), .con_select(con_select),
    .con_tx_data(con_tx_data), .con_tx_frame(con_tx_frame), .scan_sel(scan_sel),
    .msg_avail(msg_avail), .parity_ignore(parity_ignore), .rx_char(rx_char),
    .rx_char_valid(rx_char_valid), .rx_char_ready(rx_char_ready), .rx_done(rx_done),
    .tx_start(tx_start), .tx_char(tx_char), .tx_char_valid(tx_char_valid),
    .tx_char_ready(tx_char_ready), .tx_busy(tx_busy), .tx_done(tx_done),
    .xfer_abort(xfer_abort), .irq_req(irq_req));
  ctml_con_model i_ctml_con_model (.con_clk(con_clk), .con_rx_data(con_rx_data),
    .con_rx_frame(con_rx_frame), .con_ready(con_ready), .con_msg_avail(con_msg_avail),
    .con_select(con_select), .con_tx_data(con_tx_data), .con_tx_frame(con_tx_frame));
  ////////////////////////////////////////////////////////////////////////
  // Clock and pulse capture; pulses last one cycle so they are counted
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    if (rx_char_valid === 1'b1 && rx_char_ready === 1'b1)
      rxq.push_back(rx_char);
    n_d += (rx_done === 1'b1) + (tx_done === 1'b1);
    n_i += (irq_req === 1'b1);
    n_a += (xfer_abort === 1'b1);
  end
  function automatic logic [6:0] pc(input logic [5:0] d);
    return {~^d, d};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Four-state compare so an unknown output never slips through
  task automatic chk_n(input logic [31:0] g, input logic [31:0] e, input string m);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t %s got %0d", $time, m, g);
    end
  endtask
  task automatic chk_c(input logic [6:0] g, input logic [6:0] e);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t char %h not %h", $time, g, e);
    end
  endtask
  task automatic chk_q(input logic [6:0] g[$], input logic [6:0] e[$], input int n);
    chk_n(g.size(), n, "char count");
    for (int i = 0; i < n && i < g.size(); i++)
      chk_c(g[i], e[i]);
  endtask
  task automatic ev(input int d, input int i, input int a);
    chk_n(n_d, d, "done pulses");
    chk_n(n_i, i, "irq pulses");
    chk_n(n_a, a, "abort pulses");
    n_d = 0;
    n_i = 0;
    n_a = 0;
    rxq.delete();
  endtask
  // Inbound frame, then expected words and pulses
  task automatic rx_run(input logic [6:0] cs[$], input int nx, d, i, a);
    i_ctml_con_model.send(cs);
    cyc(12);
    chk_q(rxq, cs, nx);
    ev(d, i, a);
  endtask
  // Outbound message; a refused char waits while tx_busy is high (up to 3000 cycles), else three cycles, then the next char is offered.
  // Ready is looked at mid-cycle, so the char only changes after the taking edge.
  task automatic tx_run(input logic [6:0] cs[$], input int nx, d, i, a);
    int w;
    logic rd;
    logic bz;
    i_ctml_con_model.txq.delete();
    tx_start <= 1'b1;
    foreach (cs[j])
    begin
      tx_char <= cs[j];
      tx_char_valid <= 1'b1;
      w = 0;
      do
      begin
        @(negedge clk_sys);
        rd = tx_char_ready;
        bz = tx_busy;
        @(posedge clk_sys);
        tx_start <= 1'b0;
        w++;
      end
      while (rd !== 1'b1 && (bz === 1'b1 || w < 3) && w < 3000);
    end
    tx_char_valid <= 1'b0;
    for (w = 0; w < 3000 && tx_busy !== 1'b0; w++)
      cyc(1);
    cyc(3);
    chk_n(tx_busy, 0, "still busy");
    chk_q(i_ctml_con_model.txq, cs, nx);
    ev(d, i, a);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_scan();
    logic [6:0] q[$];
    q = '{pc(6'h31), pc(6'h05), pc(6'h02), pc(end_of_message_char)};
    i_ctml_con_model.hold(1'b1);
    cyc(4);
    chk_n(msg_avail, 1, "avail");
    scan_sel <= 1'b1;
    cyc(1);
    scan_sel <= 1'b0;
    cyc(1);
    chk_n(con_select, 1, "select");
    i_ctml_con_model.hold(1'b0);
    rx_run(q, 4, 1, 0, 0);
    chk_n(con_select, 0, "select drop");
  endtask
  task automatic t_rx_eom();
    logic [6:0] q[$];
    q = '{pc(6'h21), pc(6'h01), pc(end_of_message_char), pc(6'h02)};
    rx_run(q, 3, 1, 0, 0);
  endtask
  task automatic t_rx_par();
    logic [6:0] q[$];
    q = '{pc(6'h31), pc(6'h07) ^ 7'h40, pc(6'h02), pc(end_of_message_char)};
    parity_ignore <= 1'b0;
    rx_run(q, 1, 0, 1, 1);
    parity_ignore <= 1'b1;
    rx_run(q, 4, 1, 0, 0);
    parity_ignore <= 1'b0;
  endtask
  task automatic t_stall();
    logic [6:0] q[$];
    q = '{pc(6'h21), pc(6'h01), pc(6'h02)};
    rx_char_ready <= 1'b0;
    i_ctml_con_model.send(q);
    cyc(12);
    chk_n(rx_char_valid, 1, "held word");
    rx_char_ready <= 1'b1;
    cyc(5);
    chk_q(rxq, q, 2);
    ev(0, 0, 1);
  endtask
  task automatic t_tx_ctrl();
    logic [6:0] q[$];
    q = '{pc(6'h30)};
    for (int i = 0; i < 14; i++)
      q.push_back(pc(6'h10 + 6'(i)));
    q.push_back(pc(end_of_message_char));
    q.push_back(pc(6'h05));
    tx_run(q, 16, 1, 0, 0);
  endtask
  task automatic t_tx_page();
    logic [6:0] q[$];
    q = '{pc(6'h20), pc(6'h01), pc(end_of_message_char), pc(6'h05)};
    tx_run(q, 3, 1, 0, 0);
    q = '{pc(6'h20), pc(6'h06) ^ 7'h40, pc(end_of_message_char)};
    tx_run(q, 1, 0, 1, 1);
    parity_ignore <= 1'b1;
    tx_run(q, 3, 1, 0, 0);
    parity_ignore <= 1'b0;
    // Console holding its own request refuses output
    i_ctml_con_model.hold(1'b1);
    cyc(4);
    tx_run(q, 0, 0, 0, 1);
    i_ctml_con_model.hold(1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog, about four times the expected run
  initial
  begin
    #2_000_000;
    err_count++;
    $display("CHECK FAILED t=%0t run hung", $time);
    wrap_up();
  end
  initial
  begin
    end_of_message_char = ctml_pkg::EOM_CODE;
    {rst, scan_sel, parity_ignore, tx_start, tx_char_valid} = 5'h10;
    {n_d, n_i, n_a} = 0;
    rx_char_ready = 1'b1;
    tx_char = 7'h00;
    cyc(6);
    rst <= 1'b0;
    cyc(4);
    t_scan();
    t_rx_eom();
    t_rx_par();
    t_stall();
    t_tx_ctrl();
    t_tx_page();
    wrap_up();
  end
endmodule
`default_nettype wire

// ==== src/ctml_buf.sv ====
// Purpose: small FIFO between the serial receiver and the processor.
// Assumes: one clock; push only while in_ready is high.
// Notes: read data come straight from the storage flops.
`timescale 1ns/10ps
`default_nettype none
module ctml_buf #(
  parameter int W = 7,
  parameter int DEPTH = ctml_pkg::BUF_DEPTH
)(
  input wire logic clk_sys,          // System clock
  input wire logic rst,              // Sync reset
  input wire logic in_valid,         // Push request
  input wire logic [W-1:0] in_data,  // Push data
  output logic in_ready,             // Room left
  output logic out_valid,            // Word waiting
  output logic [W-1:0] out_data,     // Head word
  input wire logic out_ready         // Consumer takes
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_chk
    $error("ctml_buf: DEPTH must be a power of two, at least 2");
  end

  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////////
  // Handshake decode
  assign in_ready = cnt_q != CW'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage, no reset needed for data
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end

  // Pointers and fill level
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + PW'(1);
      if (pop)
        rd_q <= rd_q + PW'(1);
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Full buffer never takes a word and the level never wraps
  AST_BUF_LEVEL: assert property (@(posedge clk_sys) disable iff (rst)
    (!in_ready && !pop) |=> cnt_q == CW'(DEPTH))
    else $error("buffer level changed while full");
endmodule
`default_nettype wire

// ==== src/ctml_link.sv ====
// Purpose: frames console messages over the bit-serial link, both ways.
// Assumes: console clock, frame and ready arrive asynchronous to clk_sys.
// Notes: one idle bit time separates outbound characters.
`timescale 1ns/10ps
`default_nettype none
module ctml_link #(
  parameter int CHAR_W = ctml_pkg::CHAR_W_DEF,
  parameter bit LSB_FIRST = 1'b1,
  parameter bit PAR_ODD = 1'b1,
  parameter logic [CHAR_W-1:0] END_OF_MESSAGE_CHAR = CHAR_W'(ctml_pkg::EOM_CODE),
  parameter logic [CHAR_W-1:0] HDR_MASK = CHAR_W'(ctml_pkg::CTRL_HDR_MASK),
  parameter logic [CHAR_W-1:0] HDR_VAL = CHAR_W'(ctml_pkg::CTRL_HDR_VAL),
  parameter int CLEAR_WAIT_CYC = ctml_pkg::CLEAR_CYC
)(
  input wire logic clk_sys,                // 40 MHz system clock
  input wire logic rst,                    // Sync reset, high
  input wire logic con_clk,                // Console bit clock pin
  input wire logic con_rx_data,            // Serial data from console
  input wire logic con_rx_frame,           // Console sending a message
  input wire logic con_ready,              // Console can take output
  input wire logic con_msg_avail,          // Console holds a message
  output logic con_select,                 // Scanner picked console
  output logic con_tx_data,                // Serial data to console
  output logic con_tx_frame,               // Outbound message active
  input wire logic scan_sel,               // Scanner select pulse
  output logic msg_avail,                  // Synced message waiting
  input wire logic parity_ignore,          // Parity-ignore toggle
  output logic [CHAR_W:0] rx_char,         // Inbound char, parity on top
  output logic rx_char_valid,              // Inbound char waiting
  input wire logic rx_char_ready,          // Processor takes it
  output logic rx_done,                    // Inbound message ended
  input wire logic tx_start,               // Begin outbound message
  input wire logic [CHAR_W:0] tx_char,     // Outbound char, parity on top
  input wire logic tx_char_valid,          // Outbound char offered
  output logic tx_char_ready,              // Outbound char taken
  output logic tx_busy,                    // Outbound message running
  output logic tx_done,                    // Outbound message ended
  output logic xfer_abort,                 // Any transfer aborted
  output logic irq_req                     // Parity interrupt request
);
  localparam int CW = CHAR_W + 1;
  localparam int BW = $clog2(CW + 1);
  localparam int WW = $clog2(CLEAR_WAIT_CYC + 1);
  localparam int NW = ctml_pkg::CNT_W;
  localparam int SP = ctml_pkg::SYNC_PINS;
  localparam logic [NW-1:0] LIM_M1 = NW'(ctml_pkg::MSG_LIMIT - 1);
  localparam logic [NW-1:0] CTRL_M1 = NW'(ctml_pkg::CTRL_OUT_CHARS - 1);

  // Elaboration checks
  if (CHAR_W < 2 || CLEAR_WAIT_CYC < 1)
  begin : g_chk_par
    $error("ctml_link: CHAR_W below 2 or CLEAR_WAIT_CYC below 1");
  end
  if (ctml_pkg::BIT_MIN_CYC < ctml_pkg::SYNC_MIN_CYC)
  begin : g_chk_rate
    $error("ctml_link: system clock too slow for the link");
  end

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [SP-1:0] pin_raw;
  logic [SP-1:0] meta_q;
  logic [SP-1:0] sync_q;
  logic clk_prev_q;
  logic rxf_prev_q;
  logic link_rise;
  logic link_fall;
  logic rxf_rise;
  logic rxf_fall;
  logic rdy_s;

  assign pin_raw = {con_msg_avail, con_ready, con_rx_frame, con_rx_data, con_clk};

  // Two flops per pin before any logic looks
  for (genvar g = 0; g < SP; g++)
  begin : g_sync
    always_ff @(posedge clk_sys)
    begin
      if (rst)
      begin
        meta_q[g] <= 1'b0;
        sync_q[g] <= 1'b0;
      end
      else
      begin
        meta_q[g] <= pin_raw[g];
        sync_q[g] <= meta_q[g];
      end
    end
  end

  // Edge history of the synced clock and frame
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      clk_prev_q <= 1'b0;
      rxf_prev_q <= 1'b0;
    end
    else
    begin
      clk_prev_q <= sync_q[ctml_pkg::PIN_CLK];
      rxf_prev_q <= sync_q[ctml_pkg::PIN_RXF];
    end
  end

  assign link_rise = sync_q[ctml_pkg::PIN_CLK] && !clk_prev_q;
  assign link_fall = !sync_q[ctml_pkg::PIN_CLK] && clk_prev_q;
  assign rxf_rise = sync_q[ctml_pkg::PIN_RXF] && !rxf_prev_q;
  assign rxf_fall = !sync_q[ctml_pkg::PIN_RXF] && rxf_prev_q;
  assign rdy_s = sync_q[ctml_pkg::PIN_RDY];
  assign msg_avail = sync_q[ctml_pkg::PIN_AVL];

  ////////////////////////////////////////////////////////////////
  // Scanner selection of a waiting console
  logic sel_q;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      sel_q <= 1'b0;
    else if (rxf_rise)
      sel_q <= 1'b0;
    else if (scan_sel && msg_avail)
      sel_q <= 1'b1;
  end
  assign con_select = sel_q;

  ////////////////////////////////////////////////////////////////
  // Inbound receiver
  logic rx_on_q;
  logic [CW-1:0] rx_sh_q;
  logic [BW-1:0] rx_bit_q;
  logic [NW-1:0] rx_cnt_q;
  logic rx_done_q;
  logic rx_perr_q;
  logic bit_take;
  logic [CW-1:0] rx_next;
  logic rx_char_done;
  logic rx_par_ok;
  logic rx_is_eom;
  logic rx_abort;
  logic rx_push;
  logic rx_end;
  logic rx_end_lim;
  logic buf_in_ready;

  // Sample on the console's rising edge, limited by frame
  assign bit_take = rx_on_q && link_rise && sync_q[ctml_pkg::PIN_RXF];
  assign rx_next = LSB_FIRST ? {sync_q[ctml_pkg::PIN_RXD], rx_sh_q[CW-1:1]}
                             : {rx_sh_q[CW-2:0], sync_q[ctml_pkg::PIN_RXD]};
  assign rx_char_done = bit_take && rx_bit_q == BW'(CW - 1);
  assign rx_par_ok = (^rx_next) == PAR_ODD;
  assign rx_is_eom = rx_next[CHAR_W-1:0] == END_OF_MESSAGE_CHAR;
  assign rx_abort = rx_char_done && ((!rx_par_ok && !parity_ignore) || !buf_in_ready);
  assign rx_push = rx_char_done && !rx_abort;
  assign rx_end_lim = rx_push && rx_cnt_q == LIM_M1;
  assign rx_end = rx_push && (rx_is_eom || rx_cnt_q == LIM_M1);

  // Frame start arms, end or abort disarms
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rx_on_q <= 1'b0;
    else if (rxf_rise)
      rx_on_q <= 1'b1;
    else if (rx_abort || rx_end || rxf_fall)
      rx_on_q <= 1'b0;
  end

  // Shift register and counters
  always_ff @(posedge clk_sys)
  begin
    if (rst || rxf_rise)
    begin
      rx_sh_q <= '0;
      rx_bit_q <= '0;
      rx_cnt_q <= '0;
    end
    else if (bit_take)
    begin
      rx_sh_q <= rx_next;
      rx_bit_q <= rx_char_done ? '0 : rx_bit_q + BW'(1);
      if (rx_push)
        rx_cnt_q <= rx_cnt_q + NW'(1);
    end
  end

  // Status pulses
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rx_done_q <= 1'b0;
      rx_perr_q <= 1'b0;
    end
    else
    begin
      rx_done_q <= rx_end;
      rx_perr_q <= rx_char_done && !rx_par_ok && !parity_ignore;
    end
  end
  assign rx_done = rx_done_q;

  // Absorbs a processor stall of up to two characters
  ctml_buf #(.W(CW), .DEPTH(ctml_pkg::BUF_DEPTH)) u_buf (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(rx_push),
    .in_data(rx_next),
    .in_ready(buf_in_ready),
    .out_valid(rx_char_valid),
    .out_data(rx_char),
    .out_ready(rx_char_ready)
  );

  ////////////////////////////////////////////////////////////////
  // Outbound transmitter
  ctml_pkg::ctml_tx_st_t tx_st_q;
  ctml_pkg::ctml_tx_st_t tx_st_d;
  logic [NW-1:0] tx_cnt_q;
  logic [CW-1:0] tx_sh_q;
  logic [BW-1:0] tx_bit_q;
  logic [WW-1:0] tx_wait_q;
  logic tx_out_q;
  logic tx_frame_q;
  logic tx_ctrl_q;
  logic tx_last_q;
  logic tx_done_q;
  logic tx_perr_q;
  logic abort_q;
  logic tx_take;
  logic tx_par_ok;
  logic tx_bad_stop;
  logic hdr_ctrl;
  logic ctrl_now;
  logic tx_is_last;
  logic tx_fall_ok;
  logic tx_shift_en;
  logic tx_char_end;
  logic tx_timeout;
  logic tx_refuse;

  assign tx_take = tx_st_q == ctml_pkg::TX_LOAD && tx_char_valid;
  assign tx_par_ok = (^tx_char) == PAR_ODD;
  assign tx_bad_stop = !tx_par_ok && !parity_ignore;
  assign hdr_ctrl = (tx_char[CHAR_W-1:0] & HDR_MASK) == HDR_VAL;
  assign ctrl_now = tx_cnt_q == '0 ? hdr_ctrl : tx_ctrl_q;
  // sixteen chars; full page then two more
  assign tx_is_last = ctrl_now ? tx_cnt_q == CTRL_M1
                    : (tx_cnt_q != '0 && tx_char[CHAR_W-1:0] == END_OF_MESSAGE_CHAR) || tx_cnt_q == LIM_M1;
  // console holds ready low while clearing
  assign tx_fall_ok = link_fall && rdy_s;
  assign tx_shift_en = tx_st_q == ctml_pkg::TX_SHIFT && tx_fall_ok && tx_bit_q != BW'(CW);
  assign tx_char_end = tx_st_q == ctml_pkg::TX_SHIFT && tx_fall_ok && tx_bit_q == BW'(CW);
  assign tx_timeout = tx_st_q == ctml_pkg::TX_SHIFT && tx_wait_q == WW'(CLEAR_WAIT_CYC);
  assign tx_refuse = tx_st_q == ctml_pkg::TX_IDLE && tx_start && !rdy_s;

  // Next state
  always_comb
  begin
    tx_st_d = tx_st_q;
    unique case (tx_st_q)
      ctml_pkg::TX_IDLE:
        if (tx_start && rdy_s)
          tx_st_d = ctml_pkg::TX_LOAD;
      ctml_pkg::TX_LOAD:
        if (tx_take)
          tx_st_d = tx_bad_stop ? ctml_pkg::TX_IDLE : ctml_pkg::TX_SHIFT;
      ctml_pkg::TX_SHIFT:
        if (tx_timeout || (tx_char_end && tx_last_q))
          tx_st_d = ctml_pkg::TX_IDLE;
        else if (tx_char_end)
          tx_st_d = ctml_pkg::TX_LOAD;
      default:
        tx_st_d = ctml_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      tx_st_q <= ctml_pkg::TX_IDLE;
    else
      tx_st_q <= tx_st_d;
  end

  // Character count and class
  always_ff @(posedge clk_sys)
  begin
    if (rst || tx_st_q == ctml_pkg::TX_IDLE)
      tx_cnt_q <= '0;
    else if (tx_char_end && !tx_last_q)
      tx_cnt_q <= tx_cnt_q + NW'(1);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      tx_ctrl_q <= 1'b0;
      tx_last_q <= 1'b0;
    end
    else if (tx_take)
    begin
      tx_ctrl_q <= ctrl_now;
      tx_last_q <= tx_is_last;
    end
  end

  // bits leave on the console's falling edge
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      tx_sh_q <= '0;
      tx_bit_q <= '0;
      tx_out_q <= 1'b0;
    end
    else if (tx_take)
    begin
      tx_sh_q <= tx_char;
      tx_bit_q <= '0;
    end
    else if (tx_shift_en)
    begin
      tx_out_q <= LSB_FIRST ? tx_sh_q[0] : tx_sh_q[CW-1];
      tx_sh_q <= LSB_FIRST ? {1'b0, tx_sh_q[CW-1:1]} : {tx_sh_q[CW-2:0], 1'b0};
      tx_bit_q <= tx_bit_q + BW'(1);
    end
  end

  // Ready watchdog, CLEAR_WAIT_CYC cycles, one clear cycle by default
  always_ff @(posedge clk_sys)
  begin
    if (rst || tx_st_q != ctml_pkg::TX_SHIFT || rdy_s)
      tx_wait_q <= '0;
    else
      tx_wait_q <= tx_wait_q + WW'(1);
  end

  // Status pulses and frame
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      tx_frame_q <= 1'b0;
      tx_done_q <= 1'b0;
      tx_perr_q <= 1'b0;
      abort_q <= 1'b0;
    end
    else
    begin
      tx_frame_q <= tx_st_d != ctml_pkg::TX_IDLE;
      tx_done_q <= tx_char_end && tx_last_q;
      tx_perr_q <= tx_take && tx_bad_stop;
      abort_q <= rx_abort || (tx_take && tx_bad_stop) || tx_timeout || tx_refuse;
    end
  end

  assign tx_char_ready = tx_st_q == ctml_pkg::TX_LOAD;
  assign tx_busy = tx_st_q != ctml_pkg::TX_IDLE;
  assign tx_done = tx_done_q;
  assign con_tx_data = tx_out_q;
  assign con_tx_frame = tx_frame_q;
  assign xfer_abort = abort_q;
  assign irq_req = rx_perr_q || tx_perr_q;

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_rx_eom;
    rx_push && rx_is_eom;
  endsequence

  AST_RX_EOM_STOP: assert property (s_rx_eom |=> !rx_on_q && rx_done)
    else $error("receiver kept going after terminator");
  AST_RX_PAGE_LIM: assert property (rx_end_lim |=> rx_done ##1 !rx_push)
    else $error("inbound page ran past its limit");
  AST_RX_PAR_IRQ: assert property (
    (rx_char_done && !rx_par_ok && !parity_ignore) |-> !rx_push ##1 (irq_req && !rx_on_q))
    else $error("inbound bad parity did not abort");
  AST_RX_PAR_IGN: assert property (
    (rx_char_done && !rx_par_ok && parity_ignore && buf_in_ready) |-> rx_push ##1 !rx_perr_q)
    else $error("ignored parity still aborted inbound");
  AST_SEL_HOLD: assert property ((sel_q && !rxf_rise) |=> sel_q)
    else $error("console select dropped early");
  AST_TX_CLASS: assert property (
    (tx_take && tx_cnt_q == '0) |=> tx_ctrl_q == $past(hdr_ctrl))
    else $error("message class not taken from header");
  AST_TX_CTRL_LEN: assert property ((tx_done && tx_ctrl_q) |-> tx_cnt_q == CTRL_M1)
    else $error("control message length not sixteen");
  AST_TX_PAGE_END: assert property (
    (tx_take && !ctrl_now && tx_cnt_q == LIM_M1 && !tx_bad_stop) |=> tx_last_q)
    else $error("page transfer not ended after full page");
  AST_TX_PAR_ABORT: assert property (
    (tx_take && tx_bad_stop) |=> tx_st_q == ctml_pkg::TX_IDLE && irq_req && xfer_abort)
    else $error("outbound bad parity did not abort");
  AST_TX_PAR_IGN: assert property (
    (tx_take && !tx_par_ok && parity_ignore) |=> tx_st_q == ctml_pkg::TX_SHIFT && !tx_perr_q)
    else $error("ignored parity still aborted outbound");
  AST_TX_BIT_EDGE: assert property ($changed(con_tx_data) |-> $past(link_fall))
    else $error("serial output moved off the falling edge");
endmodule
`default_nettype wire
